// ===== bench/srsp_eeprom_core_assertions.sv
// Link checker of the serial EEPROM core.
`timescale 1ns/1ns
module srsp_chk (
  // Watched ports
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic sck_i,
  input wire logic cs_b_i,
  input wire logic si_i,
  input wire logic so_o,
  input wire logic so_oe_o
);
  logic [7:0] n_ff;
  logic [7:0] op_ff;
  always_ff @(posedge sck_i or posedge cs_b_i) begin
    if (cs_b_i) begin
      n_ff <= 8'h00;
      op_ff <= 8'h00;
    end else begin
      n_ff <= n_ff + 8'h01;
      if (n_ff < 8'h08) op_ff <= {op_ff[6:0], si_i};
    end
  end
  sequence s_rd;
    op_ff == 8'h03;
  endsequence
  sequence s_st;
    op_ff == 8'h05 && n_ff > 8'h08;
  endsequence
  property p_idle;
    @(posedge clk_i) disable iff (!rst_b_i) cs_b_i |-> !so_oe_o;
  endproperty
  a_idle: assert property (p_idle) else $error("SO driven when idle");
  property p_op;
    @(negedge sck_i) disable iff (cs_b_i) n_ff < 8'h09 |-> !so_oe_o;
  endproperty
  a_op: assert property (p_op) else $error("SO driven in opcode");
  property p_rd_wait;
    @(negedge sck_i) disable iff (cs_b_i) s_rd ##0 (n_ff < 8'h19) |-> !so_oe_o;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read data early");
  property p_rd_out;
    @(negedge sck_i) disable iff (cs_b_i) s_rd ##0 (n_ff > 8'h18) |-> so_oe_o;
  endproperty
  a_rd_out: assert property (p_rd_out) else $error("read data missing");
  property p_other;
    @(negedge sck_i) disable iff (cs_b_i)
      (n_ff > 8'h08 && op_ff != 8'h03 && op_ff != 8'h05) |-> !so_oe_o;
  endproperty
  a_other: assert property (p_other) else $error("SO driven by write");
  property p_st_out;
    @(negedge sck_i) disable iff (cs_b_i) s_st |-> so_oe_o;
  endproperty
  a_st_out: assert property (p_st_out) else $error("status not driven");
  property p_st_rsv;
    @(negedge sck_i) disable iff (cs_b_i)
      s_st ##0 (n_ff[2:0] inside {3'h2, 3'h3, 3'h4}) |-> !so_o;
  endproperty
  a_st_rsv: assert property (p_st_rsv) else $error("reserved bit set");
  property p_st_rep;
    @(negedge sck_i) disable iff (cs_b_i) s_st ##0 (n_ff > 8'h10) |-> so_o == $past(so_o, 8);
  endproperty
  a_st_rep: assert property (p_st_rep) else $error("status not repeated");
endmodule
bind srsp_eeprom_core srsp_chk chk (.*);

// ===== bench/srsp_host.sv
// Host SPI controller model driving mode 0 frames.
`timescale 1ns/1ns
module srsp_host (
  // SPI link
  output logic sck_o,
  output logic cs_b_o,
  output logic si_o,
  input wire logic so_i,
  input wire logic so_oe_i
);
  initial begin
    sck_o = 1'b0;
    cs_b_o = 1'b1;
    si_o = 1'b0;
  end
  // Sends n bits of tx MSB first and gathers SO at each rising edge.
  task automatic frame(input logic [39:0] tx, input int n, output logic [39:0] rx);
    rx = 40'h0;
    cs_b_o <= 1'b0;
    for (int i = 0; i < n; i++) begin
      si_o <= tx[39 - i];
      #24 sck_o <= 1'b1;
      rx = {rx[38:0], so_oe_i ? so_i : 1'bx};
      #24 sck_o <= 1'b0;
    end
    #24 cs_b_o <= 1'b1;
    si_o <= ~si_o;
    #240;
  endtask
endmodule

// ===== bench/tb_top.sv
// Self-checking bench of the serial EEPROM core.
`timescale 1ns/1ns
module tb_top;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic wp_b_i = 1'b1;
  logic sck, cs_b, si, so, so_oe;
  logic [39:0] rx;
  int bad_count = 0;
  int n_tests = 0;
  always #20 clk_i = ~clk_i;
  srsp_eeprom_core #(.WR_CYCLES(20), .NV_INIT(8'h80)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .sck_i(sck), .cs_b_i(cs_b), .si_i(si), .so_o(so), .so_oe_o(so_oe), .wp_b_i(wp_b_i));
  srsp_host host (.sck_o(sck), .cs_b_o(cs_b), .si_o(si), .so_i(so), .so_oe_i(so_oe));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic xf(input logic [39:0] tx, input int n);
    host.frame(tx, n, rx);
  endtask
  task automatic st(input logic [7:0] e);
    xf(40'h0500000000, 16);
    check({8'h00, rx[7:0]}, {8'h00, e});
  endtask
  task automatic idle;
    xf(40'h0500000000, 16);
    for (int i = 0; i < 30 && rx[0] !== 1'b0; i++) xf(40'h0500000000, 16);
    check({15'h0000, rx[0]}, 16'h0000);
  endtask
  task automatic t_arm;
    xf(40'h0500000000, 24);
    check(rx[15:0], 16'h8080);
    xf(40'h0600000000, 8);
    st(8'h82);
    xf(40'h0400000000, 8);
    st(8'h80);
    $display("t_arm done");
  endtask
  task automatic t_rw;
    xf(40'h0600000000, 8);
    xf(40'h02FFFFA500, 32);
    idle();
    st(8'h80);
    xf(40'h0600000000, 8);
    xf(40'h0200005A00, 32);
    idle();
    xf(40'h033FFF0000, 40);
    check(rx[15:0], 16'hA55A);
    $display("t_rw done");
  endtask
  task automatic t_stat;
    @(posedge clk_i);
    wp_b_i <= 1'b0;
    xf(40'h0600000000, 8);
    xf(40'h017F000000, 16);
    st(8'h82);
    @(posedge clk_i);
    wp_b_i <= 1'b1;
    xf(40'h017F000000, 16);
    st(8'h83);
    idle();
    st(8'h0C);
    $display("t_stat done");
  endtask
  task automatic t_prot;
    xf(40'h0104000000, 16);
    st(8'h0C);
    xf(40'h0600000000, 8);
    xf(40'h0104000000, 16);
    idle();
    xf(40'h0600000000, 8);
    xf(40'h0218000000, 32);
    st(8'h06);
    xf(40'h0217FF1100, 32);
    st(8'h07);
    idle();
    xf(40'h0317FF0000, 40);
    check({8'h00, rx[15:8]}, 16'h0011);
    $display("t_prot done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    t_arm();
    t_rw();
    t_stat();
    t_prot();
    results();
  end
  initial begin
    #300000;
    bad_count++;
    results();
  end
endmodule

// ===== hw/srsp_eeprom_core.sv
// Serial EEPROM core: SPI command decode, sequential read, status and protection.
`timescale 1ns/1ns

module srsp_eeprom_core #(
  parameter int unsigned WR_CYCLES = srsp_pkg::WR_CYCLES,
  parameter logic [7:0] NV_INIT = 8'h00
) (
  // System clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // SPI link
  input wire logic sck_i,
  input wire logic cs_b_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_o,
  // Write protect pin
  input wire logic wp_b_i
);

  srsp_pkg::srsp_clk_s c;
  srsp_pkg::srsp_clk_s n;
  srsp_pkg::srsp_sck_s s;
  srsp_pkg::srsp_sck_s k;
  srsp_pkg::srsp_sck_s t;

  logic [7:0] mem [srsp_pkg::DEPTH];
  logic [7:0] wbuf [srsp_pkg::PAGE];
  logic first_ff;
  logic so_ff;
  logic en_ff;
  logic commit;
  logic cs_rise;
  logic wr_byte;
  logic [7:0] stat_w;
  logic [7:0] rd_byte;

  // Takes a synchronised level once the second and third stages agree.
  function automatic logic srsp_agree(input logic [2:0] sy, input logic held);
    return (sy[2] == sy[1]) ? sy[2] : held;
  endfunction

  // Reports whether an address falls in the block-protected range.
  function automatic logic srsp_blocked(input logic [1:0] bp, input logic [12:0] a);
    logic r;
    r = 1'b1;
    unique case (bp)
      2'h0: r = 1'b0;
      2'h1: r = (a >= srsp_pkg::PROT_QUARTER);
      2'h2: r = (a >= srsp_pkg::PROT_HALF);
      2'h3: r = 1'b1;
    endcase
    return r;
  endfunction

  // Status byte with reserved bits at zero.
  assign stat_w = {c.lock, 3'h0, c.bp, c.latch, c.busy};

  // Memory is read straight by the link address; it is stable outside busy.
  assign rd_byte = mem[s.addr];

  // System clock domain: command execution, status and write timing.
  always_comb begin
    n = c;
    commit = 1'b0;
    n.cs_sy = {c.cs_sy[1:0], cs_b_i};
    n.cs = srsp_agree(c.cs_sy, c.cs);
    n.wp_sy = {c.wp_sy[1:0], wp_b_i};
    n.wp = srsp_agree(c.wp_sy, c.wp);
    cs_rise = n.cs & ~c.cs;
    if (c.busy) begin
      n.tmr = c.tmr - {{(srsp_pkg::TMR_W-1){1'b0}}, 1'b1};
      if (c.tmr == {{(srsp_pkg::TMR_W-1){1'b0}}, 1'b1}) begin
        n.busy = 1'b0;
        n.latch = 1'b0;
        if (c.st_job) begin
          n.lock = c.pend[2];
          n.bp = c.pend[1:0];
        end
      end
    end else if (cs_rise) begin
      unique case (s.op)
        srsp_pkg::OP_ARM: begin
          if (s.cnt == srsp_pkg::CNT_OPC) begin
            n.latch = 1'b1;
          end
        end
        srsp_pkg::OP_DISARM: begin
          if (s.cnt == srsp_pkg::CNT_OPC) begin
            n.latch = 1'b0;
          end
        end
        srsp_pkg::OP_WSTAT: begin
          if (s.cnt == srsp_pkg::CNT_WSTAT && c.latch && !(c.lock && !c.wp)) begin
            n.busy = 1'b1;
            n.st_job = 1'b1;
            n.pend = {s.dsh[srsp_pkg::BIT_LOCK], s.dsh[srsp_pkg::BIT_BP_HI],
                      s.dsh[srsp_pkg::BIT_BP_LO]};
            n.tmr = WR_CYCLES[srsp_pkg::TMR_W-1:0];
          end
        end
        srsp_pkg::OP_WRITE: begin
          if (s.cnt == srsp_pkg::CNT_ADDR && s.dbit == 3'h0 && s.mask != '0 && c.latch
              && !srsp_blocked(c.bp, s.addr)) begin
            n.busy = 1'b1;
            n.st_job = 1'b0;
            n.tmr = WR_CYCLES[srsp_pkg::TMR_W-1:0];
            commit = 1'b1;
          end
        end
        default: begin
          n.tmr = c.tmr;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      c <= '0;
      c.cs_sy <= srsp_pkg::SYNC_RST;
      c.cs <= 1'b1;
      c.wp_sy <= srsp_pkg::SYNC_RST;
      c.wp <= 1'b1;
      c.bp <= {NV_INIT[srsp_pkg::BIT_BP_HI], NV_INIT[srsp_pkg::BIT_BP_LO]};
      c.lock <= NV_INIT[srsp_pkg::BIT_LOCK];
    end else begin
      c <= n;
    end
  end

  // Page commit into the array on the accepted write.
  always_ff @(posedge clk_i) begin
    if (commit) begin
      for (int i = 0; i < srsp_pkg::PAGE; i++) begin
        if (s.mask[i]) begin
          mem[{s.addr[12:5], 5'(i)}] <= wbuf[i];
        end
      end
    end
  end

  // Frame start flag: set while deselected, cleared by the first rising edge.
  always_ff @(posedge sck_i or posedge cs_b_i) begin
    if (cs_b_i) begin
      first_ff <= 1'b1;
    end else begin
      first_ff <= 1'b0;
    end
  end

  // Link domain, rising edges: opcode, address and write data capture.
  always_comb begin
    t = s;
    wr_byte = 1'b0;
    if (first_ff) begin
      t.cnt = '0;
      t.dbit = '0;
      t.mask = '0;
    end
    k = t;
    k.st_s1 = stat_w;
    k.st_s2 = s.st_s1;
    k.st_s3 = s.st_s2;
    k.st = (s.st_s2 == s.st_s3) ? s.st_s3 : s.st;
    k.dsh = {t.dsh[6:0], si_i};
    if (t.cnt < srsp_pkg::CNT_OPC) begin
      k.op = {t.op[6:0], si_i};
      k.cnt = t.cnt + 5'h01;
    end else if (t.cnt < srsp_pkg::CNT_ADDR) begin
      k.addr = {t.addr[11:0], si_i};
      k.cnt = t.cnt + 5'h01;
      if (t.op == srsp_pkg::OP_STAT) begin
        k.dbit = t.dbit + 3'h1;
      end
    end else begin
      k.dbit = t.dbit + 3'h1;
      if (t.dbit == 3'h7 && t.op == srsp_pkg::OP_WRITE) begin
        wr_byte = 1'b1;
        k.mask[t.addr[4:0]] = 1'b1;
        k.addr = {t.addr[12:5], t.addr[4:0] + 5'h01};
      end else if (t.dbit == 3'h7) begin
        k.addr = t.addr + 13'h0001;
      end
    end
  end

  always_ff @(posedge sck_i) begin
    s <= k;
  end

  always_ff @(posedge sck_i) begin
    if (wr_byte) begin
      wbuf[t.addr[4:0]] <= {t.dsh[6:0], si_i};
    end
  end

  // Link domain, falling edges: serial output.
  always_ff @(negedge sck_i or posedge cs_b_i) begin
    if (cs_b_i) begin
      so_ff <= 1'b0;
      en_ff <= 1'b0;
    end else begin
      if (s.op == srsp_pkg::OP_STAT) begin
        so_ff <= s.st[~s.dbit];
      end else begin
        so_ff <= rd_byte[~s.dbit];
      end
      en_ff <= !first_ff && ((s.op == srsp_pkg::OP_STAT && s.cnt >= srsp_pkg::CNT_OPC)
               || (s.op == srsp_pkg::OP_READ && s.cnt == srsp_pkg::CNT_ADDR));
    end
  end

  assign so_o = so_ff;
  assign so_oe_o = en_ff & ~cs_b_i;

endmodule

// ===== hw/srsp_pkg.sv
// Constants, opcodes and state records of the serial EEPROM core.
package srsp_pkg;

  localparam int CLK_HZ = 25_000_000;
  localparam int TWC_MS = 10;
  localparam int WR_CYCLES = TWC_MS * (CLK_HZ / 1000);
  localparam int TMR_W = 18;
  localparam int AW = 13;
  localparam int DEPTH = 8192;
  localparam int PAGE = 32;

  typedef enum logic [7:0] {
    OP_WSTAT = 8'h01,
    OP_WRITE = 8'h02,
    OP_READ = 8'h03,
    OP_DISARM = 8'h04,
    OP_STAT = 8'h05,
    OP_ARM = 8'h06
  } srsp_op_e;

  localparam logic [4:0] CNT_OPC = 5'h08;
  localparam logic [4:0] CNT_WSTAT = 5'h10;
  localparam logic [4:0] CNT_ADDR = 5'h18;

  localparam int BIT_BUSY = 0;
  localparam int BIT_LATCH = 1;
  localparam int BIT_BP_LO = 2;
  localparam int BIT_BP_HI = 3;
  localparam int BIT_LOCK = 7;

  localparam logic [12:0] PROT_QUARTER = 13'h1800;
  localparam logic [12:0] PROT_HALF = 13'h1000;
  localparam logic [2:0] SYNC_RST = 3'h7;

  typedef struct packed {
    logic [2:0] cs_sy;
    logic cs;
    logic [2:0] wp_sy;
    logic wp;
    logic busy;
    logic latch;
    logic [1:0] bp;
    logic lock;
    logic st_job;
    logic [2:0] pend;
    logic [TMR_W-1:0] tmr;
  } srsp_clk_s;

  typedef struct packed {
    logic [7:0] op;
    logic [4:0] cnt;
    logic [AW-1:0] addr;
    logic [2:0] dbit;
    logic [7:0] dsh;
    logic [PAGE-1:0] mask;
    logic [7:0] st_s1;
    logic [7:0] st_s2;
    logic [7:0] st_s3;
    logic [7:0] st;
  } srsp_sck_s;

endpackage
